// ===== rtl/scc_sample_clock_ctrl.sv
// Sample clock conditioning and power-state control, with its serial register port.
// Assumes the serial port clock is far slower than the 125 MHz system clock.
`timescale 1ns/1ps
module scc_sample_clock_ctrl
    import scc_pkg::*;
#(
    parameter int RECOVERY_CYCLES = RECOVERY_CYCLES_DEF
)
(
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        spiSclk,
    input  wire logic        spiCsN,
    input  wire logic        spiSdioIn,
    output logic             spiSdioOutQ,
    output logic             spiSdioOeQ,
    input  wire logic        sysrefIn,
    input  wire logic        power_standby_pin,
    output logic             divClkEnQ,
    output logic             dpResetQ,
    output logic             dpReadyQ,
    output scc_chan_clk_t    chanAClkQ,
    output scc_chan_clk_t    chanBClkQ,
    output scc_link_state_t  linkStateQ,
    output logic             tempDiodeEnQ,
    output logic             fast_detect_out_a_tempQ
);

    // Pin synchronisers: sysref, power pin, select, serial clock, serial data
    localparam int NPIN = 5;
    // Select idles high; resetting it low would look like an open frame
    localparam logic [NPIN-1:0] PIN_IDLE = 5'h04;
    logic [NPIN-1:0] pinRaw;
    logic [NPIN-1:0] pinMeta_q;
    logic [NPIN-1:0] pinSync_q;
    logic [NPIN-1:0] pinPrev_q;

    assign pinRaw = {sysrefIn, power_standby_pin, spiCsN, spiSclk, spiSdioIn};

    // The first stage feeds only the second; edges are taken between stage two and three
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_ff @(posedge clock or posedge sys_rst) begin
                if (sys_rst) begin
                    pinMeta_q[gi] <= PIN_IDLE[gi];
                    pinSync_q[gi] <= PIN_IDLE[gi];
                    pinPrev_q[gi] <= PIN_IDLE[gi];
                end else begin
                    pinMeta_q[gi] <= pinRaw[gi];
                    pinSync_q[gi] <= pinMeta_q[gi];
                    pinPrev_q[gi] <= pinSync_q[gi];
                end
            end
        end
    endgenerate

    logic sdioS;
    logic sclkRise;
    logic sclkFall;
    logic csActive;
    logic sysrefRise;
    logic pwrPinS;

    assign sdioS      = pinSync_q[0];
    assign sclkRise   = pinSync_q[1] & ~pinPrev_q[1];
    assign sclkFall   = ~pinSync_q[1] & pinPrev_q[1];
    assign csActive   = ~pinSync_q[2];
    assign pwrPinS    = pinSync_q[3];
    assign sysrefRise = pinSync_q[4] & ~pinPrev_q[4];

    // Serial port: R/W bit, 15-bit address, 8 data bits, MSB first on rising edges
    logic [4:0]  bitCnt_q;
    logic [22:0] shiftIn_q;
    logic        isRead_q;
    logic [7:0]  rdShift_q;
    logic        wrStb_q;
    logic [14:0] wrAddr_q;
    logic [7:0]  wrData_q;
    logic [7:0]  readData;
    logic        instrDone;
    logic        frameDone;

    assign instrDone = sclkRise && (bitCnt_q == SPI_INSTR_END);
    assign frameDone = sclkRise && (bitCnt_q == SPI_DATA_END);

    // Frame shifter; a frame cut short by the select going high is dropped
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            bitCnt_q  <= 5'h00;
            shiftIn_q <= 23'h000000;
            isRead_q  <= 1'b0;
            wrStb_q   <= 1'b0;
            wrAddr_q  <= 15'h0000;
            wrData_q  <= 8'h00;
        end else begin
            wrStb_q <= frameDone && !isRead_q;
            if (!csActive) begin
                bitCnt_q <= 5'h00;
            end else if (sclkRise) begin
                shiftIn_q <= {shiftIn_q[21:0], sdioS};
                bitCnt_q  <= frameDone ? 5'h00 : bitCnt_q + 5'h01;
                if (instrDone) begin
                    isRead_q <= shiftIn_q[14];
                end
                if (frameDone) begin
                    wrAddr_q <= shiftIn_q[21:7];
                    wrData_q <= {shiftIn_q[6:0], sdioS};
                end
            end
        end
    end

    // Read data is driven on falling edges so it is stable at the host's rising edge
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            rdShift_q   <= 8'h00;
            spiSdioOutQ <= 1'b0;
            spiSdioOeQ  <= 1'b0;
        end else if (!csActive || frameDone) begin
            spiSdioOeQ <= 1'b0;
        end else if (instrDone && shiftIn_q[14]) begin
            rdShift_q  <= readData;
            spiSdioOeQ <= 1'b1;
        end else if (sclkFall && spiSdioOeQ) begin
            spiSdioOutQ <= rdShift_q[7];
            rdShift_q   <= {rdShift_q[6:0], 1'b0};
        end
    end

    // Register address decode for writes
    logic wrSoftRst;
    logic wrChanIdx;
    logic wrTemp;
    logic wrPwrMode;
    logic wrPinFn;
    logic wrDivide;
    logic wrHalf;
    logic wrSync;
    logic wrFineEn;
    logic wrFineVal;
    logic wrStby;

    assign wrSoftRst = wrStb_q && (wrAddr_q == ADDR_SOFT_RESET);
    assign wrChanIdx = wrStb_q && (wrAddr_q == ADDR_CHAN_INDEX);
    assign wrTemp    = wrStb_q && (wrAddr_q == ADDR_TEMP_DIODE);
    assign wrPwrMode = wrStb_q && (wrAddr_q == ADDR_PWR_MODE);
    assign wrPinFn   = wrStb_q && (wrAddr_q == ADDR_PWR_PINFUNC);
    assign wrDivide  = wrStb_q && (wrAddr_q == ADDR_CLK_DIVIDE);
    assign wrHalf    = wrStb_q && (wrAddr_q == ADDR_HALF_DELAY);
    assign wrSync    = wrStb_q && (wrAddr_q == ADDR_DIV_SYNC);
    assign wrFineEn  = wrStb_q && (wrAddr_q == ADDR_FINE_EN);
    assign wrFineVal = wrStb_q && (wrAddr_q == ADDR_FINE_VALUE);
    assign wrStby    = wrStb_q && (wrAddr_q == ADDR_STBY_FILL);

    // Global configuration registers; only sys_rst clears them, never the soft reset
    logic [7:0] chanIdx_q;
    logic [7:0] pwrMode_q;
    logic [7:0] pinFn_q;
    logic [7:0] divide_q;
    logic [7:0] divSync_q;
    logic [7:0] stbyFill_q;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            chanIdx_q    <= RST_CHAN_INDEX;
            pwrMode_q    <= RST_ZERO;
            pinFn_q      <= RST_ZERO;
            divide_q     <= RST_ZERO;
            divSync_q    <= RST_ZERO;
            stbyFill_q   <= RST_ZERO;
            tempDiodeEnQ <= 1'b0;
        end else begin
            if (wrChanIdx) chanIdx_q <= wrData_q;
            if (wrPwrMode) pwrMode_q <= wrData_q;
            if (wrPinFn) pinFn_q <= wrData_q;
            if (wrDivide) divide_q <= wrData_q;
            if (wrSync) divSync_q <= wrData_q;
            if (wrStby) stbyFill_q <= wrData_q;
            // The diode enable is local to channel A
            if (wrTemp && chanIdx_q[CHAN_A_BIT]) tempDiodeEnQ <= wrData_q[TEMP_EN_BIT];
        end
    end

    // Per-channel settings; writes land only in the selected channels
    scc_chan_clk_t chanClk_q [2];
    logic [1:0]    fineTurnOn;

    generate
        for (gi = 0; gi < 2; gi++) begin : g_chan
            assign fineTurnOn[gi] = wrFineEn && chanIdx_q[gi] && wrData_q[FINE_EN_BIT]
                                    && !chanClk_q[gi].fineEn;
            always_ff @(posedge clock or posedge sys_rst) begin
                if (sys_rst) begin
                    chanClk_q[gi] <= '0;
                end else if (chanIdx_q[gi]) begin
                    if (wrHalf) chanClk_q[gi].halfDelay <= wrData_q[HALF_DELAY_BIT];
                    if (wrFineEn) chanClk_q[gi].fineEn <= wrData_q[FINE_EN_BIT];
                    if (wrFineVal) chanClk_q[gi].fineValue <= wrData_q;
                end
            end
        end
    endgenerate

    // Settings reach the sampling edges one cycle after the write
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            chanAClkQ <= '0;
            chanBClkQ <= '0;
        end else begin
            chanAClkQ <= chanClk_q[0];
            chanBClkQ <= chanClk_q[1];
        end
    end

    // Datapath reset sequencer: one reset cycle, then a long recovery count
    scc_dp_state_t             dpState_q;
    scc_dp_state_t             dpState_d;
    logic [RECOVERY_CNT_W-1:0] recCnt_q;
    logic                      softRstReq;
    logic                      recDone;

    assign softRstReq = (wrSoftRst && (wrData_q == SOFT_RESET_CMD)) || (|fineTurnOn);
    assign recDone    = (recCnt_q == RECOVERY_CNT_W'(RECOVERY_CYCLES - 1));

    always_comb begin
        dpState_d = dpState_q;
        case (dpState_q)
            DP_IDLE:    dpState_d = softRstReq ? DP_RESET : DP_IDLE;
            DP_RESET:   dpState_d = DP_RECOVER;
            DP_RECOVER: dpState_d = softRstReq ? DP_RESET : (recDone ? DP_IDLE : DP_RECOVER);
            default:    dpState_d = DP_IDLE;
        endcase
    end

    // A new request during recovery restarts the whole sequence
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            dpState_q <= DP_IDLE;
            recCnt_q  <= '0;
            dpResetQ  <= 1'b0;
            dpReadyQ  <= 1'b0;
        end else begin
            dpState_q <= dpState_d;
            recCnt_q  <= (dpState_d == DP_RECOVER && dpState_q == DP_RECOVER) ? recCnt_q + 1'b1 : '0;
            dpResetQ  <= (dpState_d == DP_RESET);
            dpReadyQ  <= (dpState_d == DP_IDLE);
        end
    end

    // Divider, reloaded by sysref when enabled and by the datapath reset
    scc_clock_divider u_divider (
        .clock      (clock),
        .sys_rst    (sys_rst),
        .ratioSel   (divide_q[1:0]),
        .syncEnable (divSync_q[DIV_SYNC_EN_BIT]),
        .syncPhase  (divSync_q[2:0]),
        .syncPulse  (sysrefRise),
        .dpReset    (dpResetQ),
        .divEnQ     (divClkEnQ)
    );

    // Power state from pin and registers; either source may power down
    logic pinPdown;
    logic pinStby;
    logic regPdown;
    logic regStby;
    logic anyPdown;
    logic anyStby;

    assign pinPdown = pwrPinS && (pinFn_q[7:6] == PIN_FN_PDOWN);
    assign pinStby  = pwrPinS && (pinFn_q[7:6] == PIN_FN_STBY);
    assign regPdown = (pwrMode_q[1:0] == PWR_DOWN);
    assign regStby  = (pwrMode_q[1:0] == PWR_STANDBY);
    assign anyPdown = pinPdown || regPdown;
    assign anyStby  = !anyPdown && (pinStby || regStby);

    // Link state; half and fine delay changes never touch it
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            linkStateQ <= '0;
        end else begin
            linkStateQ.powerDown  <= anyPdown;
            linkStateQ.standby    <= anyStby;
            linkStateQ.linkActive <= !anyPdown;
            linkStateQ.fillZero   <= anyStby && !stbyFill_q[STBY_K_BIT];
            linkStateQ.fillK      <= anyStby && stbyFill_q[STBY_K_BIT];
        end
    end

    // Temperature diode onto fast-detect A
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            fast_detect_out_a_tempQ <= 1'b0;
        end else begin
            fast_detect_out_a_tempQ <= tempDiodeEnQ && (pinFn_q[2:0] == FD_A_FN_TEMP);
        end
    end

    // Read mux; per-channel registers show the lowest selected channel
    logic          rdChan;
    scc_chan_clk_t rdClk;
    logic          dpBusy;
    logic [14:0]   rdAddr;

    // The address LSB is still on the data pin at the sixteenth rise
    assign rdAddr = {shiftIn_q[13:0], sdioS};
    assign rdChan = !chanIdx_q[CHAN_A_BIT] && chanIdx_q[CHAN_B_BIT];
    assign rdClk  = chanClk_q[rdChan];
    assign dpBusy = (dpState_q != DP_IDLE);

    assign readData =
        (rdAddr == ADDR_SOFT_RESET)  ? {6'h00, dpBusy, 1'b0} :
        (rdAddr == ADDR_CHAN_INDEX)  ? chanIdx_q :
        (rdAddr == ADDR_TEMP_DIODE)  ? {7'h00, tempDiodeEnQ} :
        (rdAddr == ADDR_PWR_MODE)    ? pwrMode_q :
        (rdAddr == ADDR_PWR_PINFUNC) ? pinFn_q :
        (rdAddr == ADDR_CLK_DIVIDE)  ? divide_q :
        (rdAddr == ADDR_HALF_DELAY)  ? {7'h00, rdClk.halfDelay} :
        (rdAddr == ADDR_DIV_SYNC)    ? divSync_q :
        (rdAddr == ADDR_FINE_EN)     ? {7'h00, rdClk.fineEn} :
        (rdAddr == ADDR_FINE_VALUE)  ? rdClk.fineValue :
        (rdAddr == ADDR_STBY_FILL)   ? stbyFill_q : 8'h00;

endmodule

// ===== rtl/scc_pkg.sv
// Package for the sample clock and power-state control block.
// Assumes an 8-bit register map behind a three-wire serial port, 125 MHz system clock.
package scc_pkg;

    // Serial control port framing
    localparam int         SPI_ADDR_W   = 15;
    localparam int         SPI_FRAME_W  = 24;
    localparam logic [4:0] SPI_INSTR_END = 5'h0F;        // Last instruction bit index
    localparam logic [4:0] SPI_DATA_END  = 5'h17;        // Last data bit index

    // Register offsets
    localparam logic [14:0] ADDR_SOFT_RESET  = 15'h0001;
    localparam logic [14:0] ADDR_CHAN_INDEX  = 15'h0008;
    localparam logic [14:0] ADDR_TEMP_DIODE  = 15'h0028;
    localparam logic [14:0] ADDR_PWR_MODE    = 15'h003F;
    localparam logic [14:0] ADDR_PWR_PINFUNC = 15'h0040;
    localparam logic [14:0] ADDR_CLK_DIVIDE  = 15'h010B;
    localparam logic [14:0] ADDR_HALF_DELAY  = 15'h010C;
    localparam logic [14:0] ADDR_DIV_SYNC    = 15'h010D;
    localparam logic [14:0] ADDR_FINE_EN     = 15'h0117;
    localparam logic [14:0] ADDR_FINE_VALUE  = 15'h0118;
    localparam logic [14:0] ADDR_STBY_FILL   = 15'h0571;

    // Field positions
    localparam int SOFT_RESET_BIT   = 1;
    localparam int DIV_SYNC_EN_BIT  = 7;
    localparam int FINE_EN_BIT      = 0;
    localparam int HALF_DELAY_BIT   = 0;
    localparam int TEMP_EN_BIT      = 0;
    localparam int STBY_K_BIT       = 7;
    localparam int CHAN_A_BIT       = 0;
    localparam int CHAN_B_BIT       = 1;

    // Field codes
    localparam logic [7:0] SOFT_RESET_CMD = 8'h02;
    localparam logic [1:0] PWR_NORMAL     = 2'h0;
    localparam logic [1:0] PWR_STANDBY    = 2'h1;
    localparam logic [1:0] PWR_DOWN       = 2'h2;
    localparam logic [1:0] PIN_FN_PDOWN   = 2'h0;
    localparam logic [1:0] PIN_FN_STBY    = 2'h1;
    localparam logic [2:0] FD_A_FN_TEMP   = 3'h7;

    // Reset values
    localparam logic [7:0] RST_CHAN_INDEX  = 8'h03;
    localparam logic [7:0] RST_ZERO        = 8'h00;

    // Timing
    localparam int CLOCK_HZ             = 125000000;
    localparam int SOFT_RST_RECOVERY_MS = 5;
    localparam int RECOVERY_CYCLES_DEF  = SOFT_RST_RECOVERY_MS * (CLOCK_HZ / 1000);
    localparam int RECOVERY_CNT_W       = 20;

    // Datapath reset sequencer
    typedef enum logic [1:0] {
        DP_IDLE    = 2'b00,
        DP_RESET   = 2'b01,
        DP_RECOVER = 2'b10
    } scc_dp_state_t;

    // Per-channel sampling-edge settings
    typedef struct packed {
        logic       halfDelay;
        logic       fineEn;
        logic [7:0] fineValue;
    } scc_chan_clk_t;

    // Serial-link fill and power status
    typedef struct packed {
        logic powerDown;
        logic standby;
        logic linkActive;
        logic fillZero;
        logic fillK;
    } scc_link_state_t;

endpackage

// ===== rtl/scc_clock_divider.sv
// Sample clock divider producing a one-cycle enable at 1/1, 1/2, 1/4 or 1/8 rate.
// Assumes the sync pulse is already synchronised and one cycle wide.
`timescale 1ns/1ps
module scc_clock_divider
    import scc_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic [1:0] ratioSel,
    input  wire logic       syncEnable,
    input  wire logic [2:0] syncPhase,
    input  wire logic       syncPulse,
    input  wire logic       dpReset,
    output logic            divEnQ
);

    logic [2:0] count_q;
    logic [2:0] count_d;
    logic [2:0] mask;
    logic       reload;

    // Ratio code n divides by 2**n; the mask wraps the counter
    assign mask    = (ratioSel == 2'h0) ? 3'h0 : (ratioSel == 2'h1) ? 3'h1 : (ratioSel == 2'h2) ? 3'h3 : 3'h7;
    assign reload  = dpReset | (syncEnable & syncPulse);
    assign count_d = reload ? (syncPhase & mask) : ((count_q + 3'h1) & mask);

    // Counter and terminal-count enable; enable is registered so it never glitches
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            count_q <= 3'h0;
            divEnQ  <= 1'b0;
        end else begin
            count_q <= count_d;
            divEnQ  <= !reload && ((count_q & mask) == mask);
        end
    end

endmodule

// ===== tb/scc_spi_host.sv
// Serial control port host model: 24-bit frames, MSB first, sclk idle low.
// Assumes the bench resolves the shared data wire from the device's enable.
`timescale 1ns/1ps
module scc_spi_host (
    input  wire logic clock,
    input  wire logic sdioIn,
    output logic      sclk,
    output logic      csN,
    output logic      sdo
);
    initial begin
        sclk = 1'b0;
        csN  = 1'b1;
        sdo  = 1'b0;
    end

    // One frame; each sclk phase lasts 5 clocks, above the 4-clock minimum
    task automatic xfer(input logic rd, input logic [14:0] a, input logic [7:0] wd, output logic [7:0] q);
        logic [23:0] frm;
        frm = {rd, a, wd};
        q = 8'h00;
        @(posedge clock) #1 csN = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            repeat (5) @(posedge clock);
            #1 sclk = 1'b0;
            // Released line toggles so stale data is never mistaken for a reply
            sdo = (rd && i < 8) ? ~sdo : frm[i];
            repeat (5) @(posedge clock);
            #1 if (rd && i < 8) q[i] = sdioIn;
            sclk = 1'b1;
        end
        repeat (8) @(posedge clock);
        #1 sclk = 1'b0;
        csN = 1'b1;
        repeat (8) @(posedge clock);
        #1;
    endtask
endmodule

// ===== tb/scc_ctrl_assertions.sv
// Port-level checks of the sample clock control block.
// Assumes one clock domain with the asynchronous active-high reset.
`timescale 1ns/1ps
module scc_ctrl_checker
    import scc_pkg::*;
#(
    parameter int RECOVERY_CYCLES = 20
)
(
    input wire logic            clock,
    input wire logic            sys_rst,
    input wire logic            spiSclk,
    input wire logic            spiCsN,
    input wire logic            spiSdioIn,
    input wire logic            spiSdioOutQ,
    input wire logic            spiSdioOeQ,
    input wire logic            sysrefIn,
    input wire logic            power_standby_pin,
    input wire logic            divClkEnQ,
    input wire logic            dpResetQ,
    input wire logic            dpReadyQ,
    input wire scc_chan_clk_t   chanAClkQ,
    input wire scc_chan_clk_t   chanBClkQ,
    input wire scc_link_state_t linkStateQ,
    input wire logic            tempDiodeEnQ,
    input wire logic            fast_detect_out_a_tempQ
);
    logic [19:0] recCntQ;
    logic [7:0]  gapCntQ;

    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    // The recovery counter saturates so a quiet block never trips the recovery checks; the gap counter wraps
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            recCntQ <= 20'hFFFFF;
            gapCntQ <= 8'h00;
        end else begin
            recCntQ <= dpResetQ ? 20'h00000 : recCntQ + {19'h0, recCntQ != 20'hFFFFF};
            gapCntQ <= (divClkEnQ || !dpReadyQ || !linkStateQ.linkActive) ? 8'h00 : gapCntQ + 8'h01;
        end
    end

    rst_pulse_a: assert property (dpResetQ |=> !dpResetQ) else $error("reset pulse too long");
    rst_ready_a: assert property (dpResetQ |-> !dpReadyQ) else $error("ready during reset");
    recov_hold_a: assert property ((recCntQ < RECOVERY_CYCLES - 1) |-> !dpReadyQ) else $error("early ready");
    recov_done_a: assert property ((recCntQ == RECOVERY_CYCLES + 2) |-> dpReadyQ) else $error("late ready");
    // A fine-enable write shows its new setting one cycle after the reset pulse, so watch from its end
    cfg_kept_a: assert property ($fell(dpResetQ) |=> $stable({chanAClkQ, chanBClkQ, tempDiodeEnQ})[*4])
        else $error("config lost on reset");
    half_quiet_a: assert property (($changed(chanAClkQ.halfDelay) || $changed(chanBClkQ.halfDelay))
        |-> (!dpResetQ)[*3]) else $error("half delay disturbed datapath");
    value_quiet_a: assert property (($changed(chanAClkQ.fineValue) || $changed(chanBClkQ.fineValue))
        && !$rose(chanAClkQ.fineEn) && !$rose(chanBClkQ.fineEn) |-> (!dpResetQ)[*3])
        else $error("fine value disturbed datapath");
    // The reset pulse leads the registered channel setting by exactly one cycle
    fine_reset_a: assert property (($rose(chanAClkQ.fineEn) || $rose(chanBClkQ.fineEn)) |-> $past(dpResetQ))
        else $error("fine enable gave no reset");
    pdown_link_a: assert property (linkStateQ.powerDown |-> !linkStateQ.linkActive && !linkStateQ.fillK)
        else $error("link up in power-down");
    stby_fill_a: assert property (linkStateQ.standby |-> linkStateQ.linkActive
        && (linkStateQ.fillZero != linkStateQ.fillK)) else $error("bad standby fill");
    div_gap_a: assert property (gapCntQ <= 8'h10) else $error("divider pulse missing");

    cover property (dpResetQ);
    cover property (linkStateQ.fillK);
    cover property ($rose(chanAClkQ.fineEn));
endmodule

bind scc_sample_clock_ctrl scc_ctrl_checker #(.RECOVERY_CYCLES(RECOVERY_CYCLES)) u_chk (
    .clock(clock), .sys_rst(sys_rst), .spiSclk(spiSclk), .spiCsN(spiCsN), .spiSdioIn(spiSdioIn),
    .spiSdioOutQ(spiSdioOutQ), .spiSdioOeQ(spiSdioOeQ), .sysrefIn(sysrefIn),
    .power_standby_pin(power_standby_pin), .divClkEnQ(divClkEnQ), .dpResetQ(dpResetQ),
    .dpReadyQ(dpReadyQ), .chanAClkQ(chanAClkQ), .chanBClkQ(chanBClkQ), .linkStateQ(linkStateQ),
    .tempDiodeEnQ(tempDiodeEnQ), .fast_detect_out_a_tempQ(fast_detect_out_a_tempQ)
);

// ===== tb/tb_top.sv
// Self-checking bench for the sample clock control block.
// Assumes the host model drives the serial port and a short recovery count.
`timescale 1ns/1ps
module tb_top;
    import scc_pkg::*;
    localparam int RCY = 20;
    logic clock, sys_rst, sysrefIn, powerPin, spiSclk, spiCsN, hostSdio;
    logic spiSdioOutQ, spiSdioOeQ, divClkEnQ, dpResetQ, dpReadyQ, tempEn, fdTemp;
    scc_chan_clk_t   chanA, chanB;
    scc_link_state_t link;
    int n_errors = 0, cmp_count = 0, nRst = 0;
    // Shared data wire: the device wins while it drives
    wire spiSdioIn = spiSdioOeQ ? spiSdioOutQ : hostSdio;

    scc_sample_clock_ctrl #(.RECOVERY_CYCLES(RCY)) dut (
        .clock(clock), .sys_rst(sys_rst), .spiSclk(spiSclk), .spiCsN(spiCsN), .spiSdioIn(spiSdioIn),
        .spiSdioOutQ(spiSdioOutQ), .spiSdioOeQ(spiSdioOeQ), .sysrefIn(sysrefIn),
        .power_standby_pin(powerPin), .divClkEnQ(divClkEnQ), .dpResetQ(dpResetQ), .dpReadyQ(dpReadyQ),
        .chanAClkQ(chanA), .chanBClkQ(chanB), .linkStateQ(link), .tempDiodeEnQ(tempEn),
        .fast_detect_out_a_tempQ(fdTemp)
    );
    scc_spi_host host (.clock(clock), .sdioIn(spiSdioIn), .sclk(spiSclk), .csN(spiCsN), .sdo(hostSdio));

    // System clock well inside the divider's input range
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock) if (dpResetQ === 1'b1) nRst++;
    // Watchdog sized well above the expected run
    initial begin
        repeat (80000) @(posedge clock);
        n_errors++;
        final_report();
    end

    task automatic final_report();
        if (n_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [9:0] got, input logic [9:0] exp, input string m);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t %s got %0h exp %0h", $time, m, got, exp);
        end
    endtask
    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] x;
        host.xfer(1'b0, a, d, x);
    endtask
    task automatic rdchk(input logic [14:0] a, input logic [7:0] e);
        logic [7:0] x;
        host.xfer(1'b1, a, 8'h00, x);
        chk(10'(x), 10'(e), "read");
    endtask
    task automatic wait_ready();
        for (int k = 0; k < 500 && dpReadyQ !== 1'b1; k++) @(posedge clock) #1;
    endtask
    task automatic wait_div(output int n);
        n = 0;
        do begin
            @(posedge clock);
            #1 n++;
        end while (divClkEnQ !== 1'b1 && n < 64);
    endtask
    task automatic set_pin(input logic p);
        @(posedge clock) #1 powerPin = p;
        repeat (6) @(posedge clock);
        #1;
    endtask
    task automatic soft_rst();
        int n0;
        n0 = nRst;
        wr(ADDR_SOFT_RESET, SOFT_RESET_CMD);
        chk(10'(dpReadyQ), 10'd0, "still recovering");
        wait_ready();
        chk(10'(nRst - n0), 10'd1, "one reset pulse");
    endtask
    // Power-down wins over standby; the pin counts only in its chosen function
    function automatic scc_link_state_t exp_link(input logic [1:0] m, input logic [1:0] f, input logic k,
                                                 input logic p);
        logic pd, sb;
        pd = (m == PWR_DOWN) || (p && f == PIN_FN_PDOWN);
        sb = !pd && ((m == PWR_STANDBY) || (p && f == PIN_FN_STBY));
        return '{pd, sb, !pd, sb && !k, sb && k};
    endfunction

    initial begin
        logic [7:0] v;
        logic [2:0] p;
        logic [1:0] m, f;
        logic       k, pn;
        int         n, n0, off, off0;
        sys_rst = 1'b1;
        sysrefIn = 1'b0;
        powerPin = 1'b0;
        void'($urandom(32'h335D));
        repeat (16) @(posedge clock);
        #1 sys_rst = 1'b0;
        repeat (4) @(posedge clock);
        // Reset values and an unmapped place
        rdchk(ADDR_CHAN_INDEX, RST_CHAN_INDEX);
        rdchk(ADDR_CLK_DIVIDE, RST_ZERO);
        rdchk(15'h7FFF, RST_ZERO);
        set_pin(1'b1);
        chk(10'(link), 10'(exp_link(PWR_NORMAL, PIN_FN_PDOWN, 1'b0, 1'b1)), "pin default");
        set_pin(1'b0);
        // Every ratio, reprogrammed ahead of a soft reset
        for (int r = 0; r < 4; r++) begin
            wr(ADDR_CLK_DIVIDE, 8'(r));
            soft_rst();
            wait_div(n);
            wait_div(n);
            chk(10'(n), 10'(1 << r), "divide period");
        end
        // Reference pulses reload the divide-by-8 counter at a chosen phase
        for (int i = 0; i < 4; i++) begin
            p = (i == 0) ? 3'h0 : (i == 1) ? 3'h7 : 3'($urandom_range(7));
            wr(ADDR_DIV_SYNC, {1'b1, 4'h0, p});
            @(posedge clock) #1 sysrefIn = 1'b1;
            repeat (20) @(posedge clock);
            #1 sysrefIn = 1'b0;
            wait_div(n);
            off = (20 + n) % 8;
            if (i == 0) off0 = off;
            chk(10'(off), 10'((off0 - int'(p)) & 7), "sync phase");
        end
        wr(ADDR_DIV_SYNC, 8'h00);
        // Channel A only; then channel B; then a soft reset
        wr(ADDR_CHAN_INDEX, 8'h01);
        n0 = nRst;
        wr(ADDR_HALF_DELAY, 8'h01);
        chk(10'(chanA.halfDelay), 10'd1, "half A");
        chk(10'(chanB.halfDelay), 10'd0, "half B");
        wr(ADDR_FINE_EN, 8'h01);
        wait_ready();
        chk(10'(nRst - n0), 10'd1, "fine enable reset");
        v = 8'($urandom);
        wr(ADDR_FINE_VALUE, v);
        chk(chanA, {2'b11, v}, "fine A");
        wr(ADDR_CHAN_INDEX, 8'h02);
        wr(ADDR_FINE_VALUE, ~v);
        soft_rst();
        chk(chanB, {2'b00, ~v}, "fine B");
        chk(chanA, {2'b11, v}, "kept A");
        chk(10'(nRst - n0), 10'd2, "value quiet");
        rdchk(ADDR_CHAN_INDEX, 8'h02);
        // Diode enable needs channel A selected first
        wr(ADDR_TEMP_DIODE, 8'h01);
        chk(10'(tempEn), 10'd0, "diode blocked");
        wr(ADDR_CHAN_INDEX, 8'h01);
        wr(ADDR_TEMP_DIODE, 8'h01);
        chk(10'(tempEn), 10'd1, "diode on");
        // Power modes: corners first, then random mixes of register, pin and fill
        for (int i = 0; i < 12; i++) begin
            m = (i < 3) ? 2'(i) : 2'($urandom_range(2));
            f = (i < 3) ? 2'(i) : 2'($urandom_range(3));
            k = 1'($urandom_range(1));
            pn = (i < 3) ? 1'b1 : 1'($urandom_range(1));
            wr(ADDR_PWR_MODE, {6'h00, m});
            wr(ADDR_PWR_PINFUNC, {f, 3'h0, FD_A_FN_TEMP});
            wr(ADDR_STBY_FILL, {k, 7'h00});
            set_pin(pn);
            chk(10'(link), 10'(exp_link(m, f, k, pn)), "link state");
            chk(10'(fdTemp), 10'd1, "diode routed");
        end
        wr(ADDR_PWR_PINFUNC, 8'h00);
        chk(10'(fdTemp), 10'd0, "diode unrouted");
        final_report();
    end
endmodule
